/* File: src/mbn_params.sv */
module mbn_params (
   // Clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  reset,
   // Neighbor availability, index 0 upper, 1 lower
   input  wire logic [1:0]            a_avail,
   input  wire logic [1:0]            b_avail,
   input  wire logic [1:0]            c_avail,
   input  wire logic [1:0]            d_avail,
   input  wire logic                  cur_lower,
   input  wire logic                  cur_field,
   input  wire logic                  a_field,
   input  wire logic                  b_field,
   input  wire logic                  c_field,
   input  wire logic                  d_field,
   input  wire logic                  adaptive_pair_mode,
   input  wire logic [1:0]            chroma_pred_mode,
   output logic [7:0]                 neighbor_avail_flags,
   // Reference index packing
   input  wire mbn_pkg::mbn_part_t    part_shape,
   input  wire logic [7:0]            ref_idx0,
   input  wire logic [7:0]            ref_idx1,
   input  wire logic [7:0]            ref_idx2,
   input  wire logic [7:0]            ref_idx3,
   output logic [31:0]                reference_index_lists,
   // Intra type encode from estimation stage
   input  wire mbn_pkg::mbn_shape_t   enc_shape,
   input  wire logic [1:0]            enc_pred_mode,
   output logic [4:0]                 enc_type_code,
   // Type code decode
   input  wire logic                  intra_block_flag,
   input  wire logic [4:0]            macroblock_type_code,
   output logic                       dec_is_intra,
   output mbn_pkg::mbn_shape_t        intra_block_shape,
   output logic                       luma_coded_indicator,
   output logic [1:0]                 chroma_coded_indicator,
   output logic [1:0]                 large_block_pred_mode,
   output logic                       dec_type_error
);
   import mbn_pkg::*;

   typedef struct packed {
      logic [7:0]  flags;
      logic [31:0] refs;
      logic [4:0]  enc;
      logic        intra;
      mbn_shape_t  shape;
      logic        luma;
      logic [1:0]  chroma;
      logic [1:0]  pmode;
      logic        err;
   } mbn_state_t;

   mbn_state_t st;
   mbn_state_t next_st;
   logic [5:0] core_flags;
   logic [4:0] sub;
   logic [4:0] enc_sub;

   mbn_nb_if nb ();

   // Neighbor inputs into the derivation core
   assign nb.a_avail   = a_avail;
   assign nb.b_avail   = b_avail;
   assign nb.c_avail   = c_avail;
   assign nb.d_avail   = d_avail;
   assign nb.cur_lower = cur_lower;
   assign nb.cur_field = cur_field;
   assign nb.a_field   = a_field;
   assign nb.b_field   = b_field;
   assign nb.c_field   = c_field;
   assign nb.d_field   = d_field;
   assign nb.pair_mode = adaptive_pair_mode;
   assign core_flags   = nb.flags;

   mbn_avail_core u_core (
      .nb (nb.core)
   );

   // Next-state computation for all registered outputs
   always_comb begin
      next_st = st;
      // Flag byte assembly
      next_st.flags = FLAGS_RESET;
      next_st.flags[FLAG_F_BIT] = core_flags[5];
      next_st.flags[FLAG_A_BIT] = core_flags[4];
      next_st.flags[FLAG_E_BIT] = core_flags[3];
      next_st.flags[FLAG_B_BIT] = core_flags[2];
      next_st.flags[FLAG_C_BIT] = core_flags[1];
      next_st.flags[FLAG_D_BIT] = core_flags[0];
      next_st.flags[CHROMA_HI:CHROMA_LO] = chroma_pred_mode;

      // Unused lanes zero so downstream lookups stay simple
      next_st.refs = '0;
      next_st.refs[0*REF_LANE_W +: REF_LANE_W] = ref_idx0;
      if (part_shape != MBN_PART_16X16)
         next_st.refs[1*REF_LANE_W +: REF_LANE_W] = ref_idx1;
      if (part_shape == MBN_PART_8X8) begin
         next_st.refs[2*REF_LANE_W +: REF_LANE_W] = ref_idx2;
         next_st.refs[3*REF_LANE_W +: REF_LANE_W] = ref_idx3;
      end

      // Encode: luma and chroma forced, then one added
      enc_sub = '0;
      enc_sub[SUB_LUMA_BIT] = LUMA_FORCED;
      enc_sub[SUB_CHR_HI:SUB_CHR_LO] = CHROMA_FORCED;
      enc_sub[SUB_PM_HI:SUB_PM_LO] = enc_pred_mode;
      case (enc_shape)
         MBN_SHAPE_16X16: next_st.enc = enc_sub + TYPE_ONE;
         MBN_SHAPE_PCM:   next_st.enc = TYPE_PCM;
         default:         next_st.enc = TYPE_NXN;
      endcase

      // Decode; inter codes leave shape at 4x4 and other intra fields cleared
      sub = macroblock_type_code - TYPE_ONE;
      next_st.intra  = intra_block_flag;
      next_st.shape  = MBN_SHAPE_4X4;
      next_st.luma   = 1'b0;
      next_st.chroma = 2'b00;
      next_st.pmode  = PM_VERT;
      next_st.err    = 1'b0;
      if (intra_block_flag) begin
         if (macroblock_type_code == TYPE_NXN) begin
            // 4x4 and 8x8 share code zero; shape left as 4x4
            next_st.shape = MBN_SHAPE_4X4;
         end else if (macroblock_type_code <= TYPE_16_LAST) begin
            next_st.shape  = MBN_SHAPE_16X16;
            next_st.luma   = sub[SUB_LUMA_BIT];
            next_st.chroma = sub[SUB_CHR_HI:SUB_CHR_LO];
            next_st.pmode  = sub[SUB_PM_HI:SUB_PM_LO];
            next_st.err    = (sub[SUB_CHR_HI:SUB_CHR_LO] == CHROMA_RSVD);
         end else if (macroblock_type_code == TYPE_PCM) begin
            next_st.shape = MBN_SHAPE_PCM;
         end else begin
            next_st.err = 1'b1;
         end
      end
   end

   // State register, cleared on reset
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Registered outputs
   assign neighbor_avail_flags   = st.flags;
   assign reference_index_lists  = st.refs;
   assign enc_type_code          = st.enc;
   assign dec_is_intra           = st.intra;
   assign intra_block_shape      = st.shape;
   assign luma_coded_indicator   = st.luma;
   assign chroma_coded_indicator = st.chroma;
   assign large_block_pred_mode  = st.pmode;
   assign dec_type_error         = st.err;

   // Assertions; all but a_reset_clear, a_lower_frame_c and a_left_both skip the release edge, where outputs still read zero
   property p_plain_flags;
      @(posedge ref_clk) disable iff (reset)
      !reset && !adaptive_pair_mode |=> neighbor_avail_flags[7:2] ==
         {1'b0, $past(a_avail[0]), $past(a_avail[0]), $past(b_avail[0]),
          $past(c_avail[0]), $past(d_avail[0])};
   endproperty
   a_plain_flags: assert property (p_plain_flags)
      else $error("plain mode flags wrong");

   property p_chroma_lane;
      @(posedge ref_clk) disable iff (reset)
      !reset |=> neighbor_avail_flags[1:0] == $past(chroma_pred_mode);
   endproperty
   a_chroma_lane: assert property (p_chroma_lane)
      else $error("chroma mode lane wrong");

   property p_lower_frame_c;
      @(posedge ref_clk) disable iff (reset)
      adaptive_pair_mode && cur_lower && !cur_field |=>
         !neighbor_avail_flags[FLAG_C_BIT];
   endproperty
   a_lower_frame_c: assert property (p_lower_frame_c)
      else $error("lower frame C not zero");

   property p_left_both;
      @(posedge ref_clk) disable iff (reset)
      adaptive_pair_mode && !cur_field && a_field && (a_avail != 2'b11) |=>
         !neighbor_avail_flags[FLAG_A_BIT] && !neighbor_avail_flags[FLAG_E_BIT];
   endproperty
   a_left_both: assert property (p_left_both)
      else $error("A or E set without both left");

   property p_upper_field_f;
      @(posedge ref_clk) disable iff (reset)
      !reset && adaptive_pair_mode && !cur_lower && cur_field |=>
         neighbor_avail_flags[FLAG_F_BIT] == $past(a_avail[0]);
   endproperty
   a_upper_field_f: assert property (p_upper_field_f)
      else $error("upper field F wrong");

   property p_ref_16;
      @(posedge ref_clk) disable iff (reset)
      !reset && part_shape == MBN_PART_16X16 |=>
         reference_index_lists[31:8] == '0 &&
         reference_index_lists[7:0] == $past(ref_idx0);
   endproperty
   a_ref_16: assert property (p_ref_16)
      else $error("16x16 reference lanes wrong");

   property p_enc_16;
      @(posedge ref_clk) disable iff (reset)
      !reset && enc_shape == MBN_SHAPE_16X16 |=>
         enc_type_code[SUB_LUMA_BIT] && enc_type_code[SUB_CHR_HI] &&
         2'(enc_type_code - TYPE_ONE) == $past(enc_pred_mode);
   endproperty
   a_enc_16: assert property (p_enc_16)
      else $error("encoded 16x16 code out of range");

   property p_dec_mode;
      @(posedge ref_clk) disable iff (reset)
      !reset && intra_block_flag && macroblock_type_code == 5'h04 |=>
         large_block_pred_mode == PM_PLANE && !luma_coded_indicator &&
         intra_block_shape == MBN_SHAPE_16X16;
   endproperty
   a_dec_mode: assert property (p_dec_mode)
      else $error("16x16 decode fields wrong");

   property p_ref_pair;
      @(posedge ref_clk) disable iff (reset)
      !reset && (part_shape == MBN_PART_16X8 ||
                 part_shape == MBN_PART_8X16) |=>
         reference_index_lists ==
            {16'h0000, $past(ref_idx1), $past(ref_idx0)};
   endproperty
   a_ref_pair: assert property (p_ref_pair)
      else $error("two-lane reference packing wrong");

   property p_ref_quad;
      @(posedge ref_clk) disable iff (reset)
      !reset && part_shape == MBN_PART_8X8 |=> reference_index_lists ==
         {$past(ref_idx3), $past(ref_idx2),
          $past(ref_idx1), $past(ref_idx0)};
   endproperty
   a_ref_quad: assert property (p_ref_quad)
      else $error("four-lane reference packing wrong");

   property p_enc_pcm;
      @(posedge ref_clk) disable iff (reset)
      !reset && enc_shape == MBN_SHAPE_PCM |=> enc_type_code == TYPE_PCM;
   endproperty
   a_enc_pcm: assert property (p_enc_pcm)
      else $error("raw block code wrong");

   property p_enc_nxn;
      @(posedge ref_clk) disable iff (reset)
      !reset && (enc_shape == MBN_SHAPE_8X8 || enc_shape == MBN_SHAPE_4X4)
      |=> enc_type_code == TYPE_NXN;
   endproperty
   a_enc_nxn: assert property (p_enc_nxn)
      else $error("small block code wrong");

   property p_dec_inter;
      @(posedge ref_clk) disable iff (reset)
      !reset && !intra_block_flag |=> !dec_is_intra && !dec_type_error &&
         intra_block_shape == MBN_SHAPE_4X4 && !luma_coded_indicator &&
         chroma_coded_indicator == 2'b00 &&
         large_block_pred_mode == PM_VERT;
   endproperty
   a_dec_inter: assert property (p_dec_inter)
      else $error("inter code left intra fields set");

   property p_dec_range;
      @(posedge ref_clk) disable iff (reset)
      !reset && intra_block_flag && macroblock_type_code > TYPE_PCM |=>
         dec_is_intra && dec_type_error;
   endproperty
   a_dec_range: assert property (p_dec_range)
      else $error("unused intra code not flagged");

   property p_lower_frame_b;
      @(posedge ref_clk) disable iff (reset)
      !reset && adaptive_pair_mode && cur_lower && !cur_field |=>
         neighbor_avail_flags[FLAG_B_BIT];
   endproperty
   a_lower_frame_b: assert property (p_lower_frame_b)
      else $error("lower frame B not from own upper mate");

   property p_upper_frame_d;
      @(posedge ref_clk) disable iff (reset)
      !reset && adaptive_pair_mode && !cur_lower && !cur_field |=>
         neighbor_avail_flags[FLAG_D_BIT] == $past(d_avail[1]);
   endproperty
   a_upper_frame_d: assert property (p_upper_frame_d)
      else $error("upper frame D not from lower corner mate");

   property p_reset_clear;
      @(posedge ref_clk) $fell(reset) |-> neighbor_avail_flags == FLAGS_RESET;
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("flags not cleared after reset");
endmodule : mbn_params

/* File: inc/mbn_pkg.sv */
package mbn_pkg;
   // Flag byte layout
   localparam int FLAG_F_BIT = 7;
   localparam int FLAG_A_BIT = 6;
   localparam int FLAG_E_BIT = 5;
   localparam int FLAG_B_BIT = 4;
   localparam int FLAG_C_BIT = 3;
   localparam int FLAG_D_BIT = 2;
   localparam int CHROMA_HI  = 1;
   localparam int CHROMA_LO  = 0;
   localparam logic [7:0] FLAGS_RESET = 8'h00;

   // Reference index lanes
   localparam int REF_LANE_W = 8;
   localparam int REF_LANES  = 4;

   // Partition shapes
   typedef enum logic [1:0] {
      MBN_PART_16X16 = 2'b00,
      MBN_PART_16X8  = 2'b01,
      MBN_PART_8X16  = 2'b10,
      MBN_PART_8X8   = 2'b11
   } mbn_part_t;

   // Intra shape codes
   typedef enum logic [1:0] {
      MBN_SHAPE_16X16 = 2'b00,
      MBN_SHAPE_8X8   = 2'b01,
      MBN_SHAPE_4X4   = 2'b10,
      MBN_SHAPE_PCM   = 2'b11
   } mbn_shape_t;

   // Intra type code values
   localparam logic [4:0] TYPE_NXN      = 5'h00;
   localparam logic [4:0] TYPE_16_FIRST = 5'h01;
   localparam logic [4:0] TYPE_16_LAST  = 5'h18;
   localparam logic [4:0] TYPE_PCM      = 5'h19;
   localparam logic [4:0] TYPE_ONE      = 5'h01;

   // Sub-field positions of (type code - 1)
   localparam int SUB_LUMA_BIT = 4;
   localparam int SUB_CHR_HI   = 3;
   localparam int SUB_CHR_LO   = 2;
   localparam int SUB_PM_HI    = 1;
   localparam int SUB_PM_LO    = 0;
   localparam logic       LUMA_FORCED   = 1'b1;
   localparam logic [1:0] CHROMA_FORCED = 2'b10;
   localparam logic [1:0] CHROMA_RSVD   = 2'b11;

   // Large block prediction modes
   localparam logic [1:0] PM_VERT  = 2'h0;
   localparam logic [1:0] PM_HORZ  = 2'h1;
   localparam logic [1:0] PM_DC    = 2'h2;
   localparam logic [1:0] PM_PLANE = 2'h3;
endpackage : mbn_pkg

/* File: inc/mbn_nb_if.sv */
// Neighbor availability between top and derivation core
interface mbn_nb_if;
   logic [1:0] a_avail;
   logic [1:0] b_avail;
   logic [1:0] c_avail;
   logic [1:0] d_avail;
   logic       cur_lower;
   logic       cur_field;
   logic       a_field;
   logic       b_field;
   logic       c_field;
   logic       d_field;
   logic       pair_mode;
   logic [5:0] flags;
   modport core (input a_avail, b_avail, c_avail, d_avail, cur_lower,
                 cur_field, a_field, b_field, c_field, d_field,
                 pair_mode, output flags);
   modport top  (output a_avail, b_avail, c_avail, d_avail, cur_lower,
                 cur_field, a_field, b_field, c_field, d_field,
                 pair_mode, input flags);
endinterface : mbn_nb_if

/* File: src/mbn_avail_core.sv */
// Combinational availability derivation; flags order F A E B C D
module mbn_avail_core (
   mbn_nb_if.core nb
);
   import mbn_pkg::*;

   logic d, b, c, a, e, f;
   logic top_frame;
   logic a_both;

   // Per-case selection of neighbor availabilities
   always_comb begin
      a_both    = nb.a_avail[0] & nb.a_avail[1];
      top_frame = !nb.cur_field;
      d = nb.d_avail[0];
      b = nb.b_avail[0];
      c = nb.c_avail[0];
      a = nb.a_avail[0];
      e = nb.a_avail[0];
      f = 1'b0;
      if (nb.pair_mode) begin
         case ({nb.cur_lower, nb.cur_field})
            2'b00: begin                           // upper frame
               d = nb.d_avail[1];
               b = nb.b_avail[1];
               c = nb.c_avail[1];
               a = nb.a_field ? a_both : nb.a_avail[0];
               e = nb.a_field ? a_both : nb.a_avail[0];
               f = nb.a_field ? nb.a_avail[1] : nb.a_avail[0];
            end
            2'b01: begin                           // upper field
               d = nb.d_field ? nb.d_avail[0] : nb.d_avail[1];
               b = nb.b_field ? nb.b_avail[0] : nb.b_avail[1];
               c = nb.c_field ? nb.c_avail[0] : nb.c_avail[1];
               a = nb.a_avail[0];
               e = nb.a_field ? nb.a_avail[0] : nb.a_avail[1];
               f = nb.a_avail[0];
            end
            2'b10: begin                           // lower frame
               // Upper mate of own pair is always decoded first
               d = nb.a_field ? nb.a_avail[1] : nb.a_avail[0];
               b = top_frame;
               c = 1'b0;
               a = nb.a_field ? a_both : nb.a_avail[1];
               e = nb.a_field ? a_both : nb.a_avail[1];
               f = nb.a_avail[1];
            end
            2'b11: begin                           // lower field
               d = nb.d_avail[1];
               b = nb.b_avail[1];
               c = nb.c_avail[1];
               a = nb.a_field ? nb.a_avail[1] : nb.a_avail[0];
               e = nb.a_avail[1];
               f = nb.a_field ? nb.a_avail[1] : nb.a_avail[0];
            end
            default: begin
               d = 1'b0;
            end
         endcase
      end
   end

   assign nb.flags = {f, a, e, b, c, d};
endmodule : mbn_avail_core

/* File: test/mbn_supplier.sv */
// Neighbor supplier: walks every pair description, one per cycle
module mbn_supplier (
   // Clock and control
   input  wire logic       ref_clk,
   input  wire logic       run,
   output logic            done,
   // Macroblock pair description
   output logic            cur_lower,
   output logic            cur_field,
   output logic [3:0]      nb_field,
   output logic [7:0]      nb_avail,
   output logic            pair_mode,
   output logic [1:0]      chroma
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [15:0] cnt;

   // Bit 0 picks upper or lower mate; both see one shared field bit
   assign cur_lower = cnt[0];
   assign cur_field = cnt[1];
   assign nb_field  = cnt[5:2];
   assign nb_avail  = cnt[13:6];
   assign pair_mode = cnt[14];
   assign chroma    = cnt[1:0] ^ cnt[11:10];
   assign done      = cnt[15];

   // Held at zero until run; freezes at the end with done set
   // and the description bits back at zero
   always_ff @(posedge ref_clk) begin
      if (!run) begin
         cnt <= 16'h0000;
      end else if (!done) begin
         cnt <= cnt + 16'h0001;
      end
   end
endmodule : mbn_supplier

/* File: test/mbn_params_bench.sv */
module mbn_params_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import mbn_pkg::*;

   // Clock, reset and supplier control
   logic        ref_clk;
   logic        reset;
   logic        run;
   logic        done;
   // Neighbor description from the supplier
   logic        lo;
   logic        fd;
   logic [3:0]  nf;
   logic [7:0]  av;
   logic        pm;
   logic [1:0]  ch;
   logic [7:0]  flags;
   // Reference lanes, encode and decode
   mbn_part_t   part_shape;
   logic [7:0]  idx [4];
   logic [31:0] lists;
   mbn_shape_t  enc_shape;
   logic [1:0]  enc_mode;
   logic [4:0]  enc_code;
   logic        intra_flag;
   logic [4:0]  mtc;
   logic        d_intra;
   mbn_shape_t  d_shape;
   logic        d_luma;
   logic [1:0]  d_chroma;
   logic [1:0]  d_mode;
   logic        d_err;
   // Scoreboard
   int          err_count;
   int          comparisons;
   logic        chk_on;
   logic        prev_ok;
   logic [7:0]  exp_q;

   mbn_supplier sup (
      .ref_clk(ref_clk), .run(run), .done(done), .cur_lower(lo),
      .cur_field(fd), .nb_field(nf), .nb_avail(av), .pair_mode(pm),
      .chroma(ch)
   );

   mbn_params dut (
      .ref_clk(ref_clk), .reset(reset),
      .a_avail(av[1:0]), .b_avail(av[3:2]), .c_avail(av[5:4]),
      .d_avail(av[7:6]), .cur_lower(lo), .cur_field(fd),
      .a_field(nf[0]), .b_field(nf[1]), .c_field(nf[2]),
      .d_field(nf[3]), .adaptive_pair_mode(pm), .chroma_pred_mode(ch),
      .neighbor_avail_flags(flags), .part_shape(part_shape),
      .ref_idx0(idx[0]), .ref_idx1(idx[1]), .ref_idx2(idx[2]),
      .ref_idx3(idx[3]), .reference_index_lists(lists),
      .enc_shape(enc_shape), .enc_pred_mode(enc_mode),
      .enc_type_code(enc_code), .intra_block_flag(intra_flag),
      .macroblock_type_code(mtc), .dec_is_intra(d_intra),
      .intra_block_shape(d_shape), .luma_coded_indicator(d_luma),
      .chroma_coded_indicator(d_chroma),
      .large_block_pred_mode(d_mode), .dec_type_error(d_err)
   );

   // 250 MHz core clock
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   // Expected flag byte; lower frame D/A/E follow the left pair type
   function automatic logic [7:0] exp_flags(input logic lo_i, fd_i,
      input logic [3:0] f, input logic [7:0] v, input logic pm_i,
      input logic [1:0] ch_i);
      logic [1:0] a, b, c, d;
      logic       fa, uf, lf, fl_d, fl_b, fl_c, fl_a, fl_e, fl_f;
      a = v[1:0];
      b = v[3:2];
      c = v[5:4];
      d = v[7:6];
      fa = f[0];
      uf = !lo_i && fd_i;
      lf = lo_i && !fd_i;
      fl_d = lf ? a[fa] : (uf && f[3]) ? d[0] : d[1];
      fl_b = lf ? 1'b1 : (uf && f[1]) ? b[0] : b[1];
      fl_c = lf ? 1'b0 : (uf && f[2]) ? c[0] : c[1];
      fl_a = fd_i ? a[lo_i && fa] : fa ? &a : a[lo_i];
      fl_e = fd_i ? a[lo_i || !fa] : fl_a;
      fl_f = fd_i ? a[lo_i && fa] : a[lo_i || fa];
      if (!pm_i) begin
         return {1'b0, a[0], a[0], b[0], c[0], d[0], ch_i};
      end
      return {fl_f, fl_a, fl_e, fl_b, fl_c, fl_d, ch_i};
   endfunction : exp_flags

   // Masked compare; unknown bits under the mask match only an unknown expected bit
   task automatic check(input logic [31:0] got, input logic [31:0] exp,
      input string what, input logic [31:0] mask = 32'hFFFF_FFFF);
      comparisons++;
      if ((got & mask) !== (exp & mask)) begin
         err_count++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   // One edge registers, then look mid-cycle
   task automatic step;
      @(posedge ref_clk);
      @(negedge ref_clk);
   endtask : step

   task automatic give_verdict;
      $display("comparisons %0d errors %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : give_verdict

   // Flag byte trails its inputs by exactly one edge
   always @(negedge ref_clk) begin
      if (chk_on) begin
         if (prev_ok) begin
            check(flags, exp_q, "flags");
         end
         exp_q = exp_flags(lo, fd, nf, av, pm, ch);
         prev_ok = 1'b1;
      end
   end

   // Main sequence
   initial begin
      int         i;
      int         k;
      int         n;
      logic [31:0] x;
      logic [4:0] v;
      logic [8:0] e;
      logic [8:0] m;
      reset = 1'b1;
      run = 1'b0;
      chk_on = 1'b0;
      prev_ok = 1'b0;
      err_count = 0;
      comparisons = 0;
      part_shape = MBN_PART_16X16;
      idx = '{default: 8'h00};
      enc_shape = MBN_SHAPE_16X16;
      enc_mode = 2'h0;
      intra_flag = 1'b0;
      mtc = 5'h00;
      repeat (10) @(posedge ref_clk);
      reset <= 1'b0;
      // Every neighbor combination, both modes, back to back
      @(posedge ref_clk);
      run <= 1'b1;
      chk_on = 1'b1;
      for (i = 0; i < 40000 && done !== 1'b1; i++) @(posedge ref_clk);
      chk_on = 1'b0;
      if (done !== 1'b1) begin
         err_count++;
         $display("ERROR %0t neighbor walk timed out", $time);
      end
      $display("test neighbor walk done");
      // Reference lanes per partition shape
      for (i = 0; i < 4; i++) begin
         n = (i == 0) ? 1 : (i == 3) ? 4 : 2;
         x = 32'h0000_0000;
         @(posedge ref_clk);
         part_shape <= mbn_part_t'(i);
         for (k = 0; k < 4; k++) begin
            idx[k] <= 8'h1F + 8'(k * 64 + i);
            if (k < n) x[k*8 +: 8] = 8'h1F + 8'(k * 64 + i);
         end
         step();
         check(lists, x, "ref lanes");
      end
      $display("test reference lanes done");
      // Encode every shape and prediction mode
      for (i = 0; i < 16; i++) begin
         @(posedge ref_clk);
         enc_shape <= mbn_shape_t'(i / 4);
         enc_mode <= 2'(i);
         step();
         v = {LUMA_FORCED, CHROMA_FORCED, 2'(i)} + TYPE_ONE;
         if (i / 4 == 3) v = TYPE_PCM;
         else if (i / 4 != 0) v = TYPE_NXN;
         check(enc_code, v, "encode");
      end
      $display("test encode done");
      // Decode all codes under both tables
      for (i = 0; i < 64; i++) begin
         @(posedge ref_clk);
         intra_flag <= i[5];
         mtc <= i[4:0];
         step();
         v = 5'(i) - TYPE_ONE;
         m = 9'h1C1;
         e = {1'b1, MBN_SHAPE_16X16, v[4], v[3:2], v[1:0], 1'b0};
         if (!i[5]) begin
            e = {1'b0, MBN_SHAPE_4X4, 6'h00};
            m = 9'h1FE;
         end else if (i[4:0] == TYPE_NXN) e = {1'b1, MBN_SHAPE_4X4, 6'h00};
         else if (i[4:0] == TYPE_PCM) e = {1'b1, MBN_SHAPE_PCM, 6'h00};
         else if (i[4:0] > TYPE_16_LAST || v[3:2] == CHROMA_RSVD) begin
            e = 9'h101;
            m = 9'h101;
         end else m = 9'h1FF;
         check({d_intra, d_shape, d_luma, d_chroma, d_mode, d_err},
               e, "decode", m);
      end
      $display("test decode done");
      // Reset in mid-run clears registered outputs
      @(posedge ref_clk);
      reset <= 1'b1;
      @(negedge ref_clk);
      check(lists, 32'h0000_0000, "lists in reset");
      check(enc_code, 5'h00, "encode in reset");
      check(flags, FLAGS_RESET, "flags in reset");
      @(posedge ref_clk);
      reset <= 1'b0;
      step();
      check(d_err, 32'h0000_0001, "decode after reset");
      $display("test second reset done");
      give_verdict();
   end
endmodule : mbn_params_bench
